/* rtl/ssd_top.sv */
// strobe conditioning with wishbone registers and probe output mux
`timescale 1ns/1ns
module ssd_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sampleStrobeIn,
	input wire logic [3:0] adcNibble,
	input wire logic videoSampleClk,
	input wire logic adcClk,
	input wire logic resetSampleClk,
	output logic timingStrobe,
	output logic [3:0] outputNibble
);
	localparam int DW = ssd_pkg::SSD_DELAY_W;
	localparam int CW = ssd_pkg::SSD_STAT_CNT_W;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [7:0] setup;
		logic [7:0] probe;
		logic ack;
		logic [31:0] rdata;
		logic strobeOut;
		logic [3:0] nibble;
		logic [CW-1:0] pulseCnt;
	} ssd_st_t;

	ssd_st_t st_r;
	ssd_st_t st_nxt;

	logic edgeSeen;
	logic syncPulse;
	logic busy;
	logic detectEn;
	logic risingSel;
	logic probeSel;
	logic [DW-1:0] delaySel;
	logic access;
	logic internalStrobe;
	logic [31:0] status;

	assign detectEn = st_r.setup[ssd_pkg::SSD_BIT_DETECT_EN];
	assign risingSel = st_r.setup[ssd_pkg::SSD_BIT_POLARITY];
	assign delaySel = st_r.setup[ssd_pkg::SSD_BIT_DELAY_HI:
		ssd_pkg::SSD_BIT_DELAY_LO];
	assign probeSel = st_r.probe[ssd_pkg::SSD_BIT_PROBE];
	// one wait state: ack is registered, so a new request is never mistaken
	assign access = wb_cyc_i & wb_stb_i & ~st_r.ack;

	ssd_edge #(
		.DELAY_W(DW)
	) u_edge (
		.clk(clk),
		.rstn(rstn),
		.strobeLvl(st_r.sync2),
		.detectEn(detectEn),
		.risingSel(risingSel),
		.delaySel(delaySel),
		.edgeSeen(edgeSeen),
		.syncPulse(syncPulse),
		.busy(busy)
	);

	always_comb begin
		status = '0;
		status[ssd_pkg::SSD_STAT_LEVEL] = st_r.sync2;
		status[ssd_pkg::SSD_STAT_BUSY] = busy;
		status[ssd_pkg::SSD_STAT_CNT_LO +: CW] = st_r.pulseCnt;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = sampleStrobeIn;
		st_nxt.sync2 = st_r.sync1;
		internalStrobe = detectEn ? syncPulse : st_r.sync2;
		st_nxt.strobeOut = internalStrobe;
		st_nxt.nibble = probeSel
			? {internalStrobe, videoSampleClk, adcClk, resetSampleClk}
			: adcNibble;
		if (syncPulse) begin
			st_nxt.pulseCnt = st_r.pulseCnt + 1'b1;
		end
		st_nxt.ack = access;
		st_nxt.rdata = '0;
		if (access) begin
			case (wb_adr_i)
				ssd_pkg::SSD_OFS_SETUP: begin
					st_nxt.rdata[7:0] = st_r.setup;
					if (wb_we_i && wb_sel_i[0]) begin
						st_nxt.setup = wb_dat_i[7:0] & ssd_pkg::SSD_SETUP_MASK;
					end
				end
				ssd_pkg::SSD_OFS_PROBE: begin
					st_nxt.rdata[7:0] = st_r.probe;
					if (wb_we_i && wb_sel_i[0]) begin
						st_nxt.probe = wb_dat_i[7:0] & ssd_pkg::SSD_PROBE_MASK;
					end
				end
				ssd_pkg::SSD_OFS_STATUS: begin
					st_nxt.rdata = status;
				end
				// unmapped: acked, reads zero, writes dropped
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.setup <= ssd_pkg::SSD_RST_SETUP;
			st_r.probe <= ssd_pkg::SSD_RST_PROBE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_dat_o = st_r.rdata;
	assign wb_ack_o = st_r.ack;
	assign timingStrobe = st_r.strobeOut;
	assign outputNibble = st_r.nibble;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_DIRECT_PATH: assert property (
		!detectEn ##1 !detectEn |-> timingStrobe == $past(st_r.sync2)
	) else $error("direct strobe path wrong");

	AST_DERIVED_PATH: assert property (
		detectEn ##1 detectEn |-> timingStrobe == $past(syncPulse)
	) else $error("derived strobe path wrong");

	AST_DELAY_ZERO: assert property (
		edgeSeen && detectEn && delaySel == 3'h0 |=> syncPulse
	) else $error("pulse missing at zero delay");

	AST_DELAY_SEVEN: assert property (
		(edgeSeen && detectEn && delaySel == 3'h7)
		##1 (!edgeSeen && detectEn && delaySel == 3'h7)[*7]
		|=> syncPulse
	) else $error("pulse missing after delay seven");

	AST_OFF_NO_PULSE: assert property (
		!detectEn |=> !syncPulse && !busy
	) else $error("pulse while detection off");

	AST_EDGE_DIR: assert property (
		edgeSeen |-> (risingSel
			? (st_r.sync2 && !$past(st_r.sync2))
			: (!st_r.sync2 && $past(st_r.sync2)))
	) else $error("edge of wrong direction");

	AST_PROBE_MUX: assert property (
		$past(probeSel) |-> outputNibble[3] == timingStrobe
			&& outputNibble[2] == $past(videoSampleClk)
	) else $error("probe nibble wrong");

	AST_DATA_MUX: assert property (
		!$past(probeSel) |-> outputNibble == $past(adcNibble)
	) else $error("adc nibble wrong");

	AST_PULSE_CAUSE: assert property (
		syncPulse |-> $past(edgeSeen) || $past(busy)
	) else $error("pulse without edge");

	AST_BUS_ACK: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o
	) else $error("ack timing wrong");

	AST_SETUP_WRITE: assert property (
		access && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ssd_pkg::SSD_OFS_SETUP
		|=> st_r.setup
			== ($past(wb_dat_i[7:0]) & ssd_pkg::SSD_SETUP_MASK)
	) else $error("setup write lost");

	AST_PROBE_WRITE: assert property (
		access && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ssd_pkg::SSD_OFS_PROBE
		|=> st_r.probe
			== ($past(wb_dat_i[7:0]) & ssd_pkg::SSD_PROBE_MASK)
	) else $error("probe write lost");

	AST_IDLE_DATA: assert property (
		!wb_ack_o |-> wb_dat_o == '0
	) else $error("read data outside ack");

	AST_DELAY_ONE: assert property (
		(edgeSeen && detectEn && delaySel == 3'h1)
		##1 (!edgeSeen && detectEn && delaySel == 3'h1)
		|=> syncPulse
	) else $error("pulse missing after delay one");

	AST_PROBE_LOW: assert property (
		$past(probeSel) |-> outputNibble[1] == $past(adcClk)
			&& outputNibble[0] == $past(resetSampleClk)
	) else $error("probe clock bits wrong");

	CVR_DELAYED: cover property (busy ##1 syncPulse);
	CVR_RISING: cover property (edgeSeen && risingSel && detectEn);
	CVR_PROBE: cover property (probeSel && timingStrobe);
	CVR_READ: cover property (wb_ack_o && !wb_we_i
		&& wb_adr_i == ssd_pkg::SSD_OFS_STATUS);
endmodule : ssd_top

/* rtl/ssd_pkg.sv */
// constants shared by the sample strobe edge detect block
package ssd_pkg;
	localparam logic [7:0] SSD_OFS_SETUP = 8'h00;
	localparam logic [7:0] SSD_OFS_PROBE = 8'h04;
	localparam logic [7:0] SSD_OFS_STATUS = 8'h08;
	localparam int SSD_BIT_DETECT_EN = 0;
	localparam int SSD_BIT_DELAY_LO = 1;
	localparam int SSD_BIT_DELAY_HI = 3;
	localparam int SSD_BIT_POLARITY = 4;
	localparam int SSD_BIT_PROBE = 7;
	localparam int SSD_DELAY_W = 3;
	localparam logic [7:0] SSD_RST_SETUP = 8'h00;
	localparam logic [7:0] SSD_RST_PROBE = 8'h00;
	localparam logic [7:0] SSD_SETUP_MASK = 8'h1f;
	localparam logic [7:0] SSD_PROBE_MASK = 8'h80;
	localparam int SSD_STAT_LEVEL = 0;
	localparam int SSD_STAT_BUSY = 1;
	localparam int SSD_STAT_CNT_LO = 8;
	localparam int SSD_STAT_CNT_W = 8;
endpackage : ssd_pkg

/* rtl/ssd_edge.sv */
// edge detector and delay counter for the strobe
`timescale 1ns/1ns
module ssd_edge #(
	parameter int DELAY_W = ssd_pkg::SSD_DELAY_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic strobeLvl,
	input wire logic detectEn,
	input wire logic risingSel,
	input wire logic [DELAY_W-1:0] delaySel,
	output logic edgeSeen,
	output logic syncPulse,
	output logic busy
);
	typedef struct packed {
		logic prev;
		logic [DELAY_W-1:0] cnt;
		logic pulse;
	} ssd_edge_st_t;

	ssd_edge_st_t st_r;
	ssd_edge_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = strobeLvl;
		edgeSeen = risingSel ? (strobeLvl & ~st_r.prev)
			: (~strobeLvl & st_r.prev);
		st_nxt.pulse = 1'b0;
		if (!detectEn) begin
			st_nxt.cnt = '0;
		end else if (edgeSeen) begin
			// a fresh edge restarts the delay, dropping any pending pulse
			st_nxt.cnt = delaySel;
			st_nxt.pulse = (delaySel == '0);
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
			st_nxt.pulse = (st_r.cnt == 1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign syncPulse = st_r.pulse;
	assign busy = (st_r.cnt != '0);
endmodule : ssd_edge

/* dv/ssd_scan_ctrl.sv */
// scanner timing controller model driving the strobe pin
`timescale 1ns/1ns
module ssd_scan_ctrl (
	input wire logic clk,
	input wire logic lvlReq,
	output logic strobePin
);
	// pin moves only just after an edge, as the real controller does
	initial strobePin = 1'b0;
	always @(posedge clk) strobePin <= lvlReq;
endmodule : ssd_scan_ctrl

/* dv/tb_top.sv */
// self-checking bench for the strobe conditioning block
`timescale 1ns/1ns
module tb_top;
	logic clk, rstn, cyc, stb, we, lvlReq, vsc, adcClk, rsc, ack, tStrobe;
	logic pin;
	logic [7:0] adr;
	logic [31:0] wdat, datO, q, tmp;
	logic [31:0] seed = 32'h0000_8b5b;
	logic [3:0] sel, nib, outN, expN;
	int failCount = 0, totalChecks = 0, n;
	int hist[$];
	ssd_scan_ctrl u_ctrl (.clk(clk), .lvlReq(lvlReq), .strobePin(pin));
	ssd_top u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(datO), .wb_ack_o(ack), .sampleStrobeIn(pin),
		.adcNibble(nib), .videoSampleClk(vsc), .adcClk(adcClk),
		.resetSampleClk(rsc), .timingStrobe(tStrobe), .outputNibble(outN));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic completeRun;
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : completeRun
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		totalChecks++;
		if (s !== e) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// classic cycle: hold everything until ack is sampled high
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		@(posedge clk) {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'h1};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) begin
			failCount++;
			completeRun();
		end
	endtask : wb
	task automatic pulse(int d, logic p);
		wb(1'b1, ssd_pkg::SSD_OFS_SETUP, {27'h0, p, d[2:0], 1'b1});
		@(posedge clk) lvlReq <= ~p;
		repeat (8) @(posedge clk);
		lvlReq <= p;
		n = 0;
		while (pin !== p && n++ < 5) @(negedge clk);
		if (pin !== p) begin
			failCount++;
			completeRun();
		end
		n = 0;
		while (tStrobe !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("delay", 4 + d, n);
		@(negedge clk) chk("width", 1'b0, tStrobe);
		@(posedge clk) lvlReq <= ~p;
		n = 0;
		repeat (14) @(negedge clk) n += (tStrobe !== 1'b0);
		chk("opposite", 0, n);
	endtask : pulse
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rstn, cyc, stb, we, lvlReq, vsc, adcClk, rsc} = '0;
		{adr, wdat, sel, nib} = '0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		wb(1'b0, ssd_pkg::SSD_OFS_SETUP, '0);
		chk("setup", ssd_pkg::SSD_RST_SETUP, q);
		wb(1'b0, ssd_pkg::SSD_OFS_PROBE, '0);
		chk("probe", ssd_pkg::SSD_RST_PROBE, q);
		wb(1'b0, 8'h0c, '0);
		chk("unmapped", '0, q);
		// detect off but delay and polarity set: they must not matter
		wb(1'b1, ssd_pkg::SSD_OFS_SETUP, 32'h0000_00fe);
		wb(1'b0, ssd_pkg::SSD_OFS_SETUP, '0);
		chk("readback", 32'h0000_001e, q);
		repeat (60) begin
			@(posedge clk) tmp = rnd();
			lvlReq <= tmp[0];
			@(negedge clk) hist.push_back(pin);
			if (hist.size() > 3)
				chk("direct", hist[hist.size()-4], tStrobe);
		end
		repeat (4) @(posedge clk);
		wb(1'b0, ssd_pkg::SSD_OFS_STATUS, '0);
		chk("status", 32'(tmp[0]) << ssd_pkg::SSD_STAT_LEVEL, q);
		for (int p = 0; p < 2; p++)
			for (int d = 0; d < 8; d++)
				pulse(d, p[0]);
		for (int k = 0; k < 2; k++) begin
			wb(1'b1, ssd_pkg::SSD_OFS_PROBE, k ? 32'h0000_0080 : '0);
			for (int i = 0; i < 12; i++) begin
				@(posedge clk) tmp = rnd();
				{nib, vsc, adcClk, rsc} <= tmp[6:0];
				@(negedge clk);
				if (i > 0) chk("nibble", expN, outN);
				expN = k ? {1'b0, vsc, adcClk, rsc} : nib;
			end
		end
		completeRun();
	end
endmodule : tb_top
